// ---- verilog/cltc_trim_cell.v ----
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cltc_consts.vh"

// Notes on behaviour
// - each correction compares setpoint with ADC sample: +1 higher, -1 lower, 0 equal.
// - nonzero result steps DAC register by sign and polarity; zero result holds it.
// - a per-channel error polarity setting chooses the correction direction.
// - corrections start at regular intervals from one shared rate setting.
// - rate setting picks 860 us, 1.72 ms, 13.8 ms or 27.6 ms.
// - channel n uses only the sample of its own monitor input n.
// - correction runs only while loop_correction_enable is asserted.
// - volatile setpoint register loaded from profile chosen by two select bits.
// - at reset the trim pad is high impedance and correction disabled.
// - at reset manual loads profile 0 DAC code, closed loop loads 80h.
// - at reset the setpoint register takes the profile 0 setpoint.
// - DAC register drives an 8-bit bipolar DAC, 80h is bipolar zero.
// - output offset select of four values, reset loaded, rewritable at run time.
// - output enable 0 puts pad in high impedance, 1 drives offset plus DAC.
// - output enable is 0 at reset and held until the link is established.
// - on profile select change the chosen setpoint is copied to the setpoint.
// - in manual mode a profile select change writes the chosen DAC code.
// - closed loop with correction disabled holds the last DAC value.
// - setpoints and setpoint register are 12 bits, like the ADC sample.
module cltc_trim_cell #(
  parameter [`CLTC_TMR_W-1:0] INTERVAL0_CYC = `CLTC_INTERVAL0_US * `CLTC_CYC_PER_US,
  parameter [`CLTC_TMR_W-1:0] INTERVAL1_CYC = `CLTC_INTERVAL1_US * `CLTC_CYC_PER_US,
  parameter [`CLTC_TMR_W-1:0] INTERVAL2_CYC = `CLTC_INTERVAL2_US * `CLTC_CYC_PER_US,
  parameter [`CLTC_TMR_W-1:0] INTERVAL3_CYC = `CLTC_INTERVAL3_US * `CLTC_CYC_PER_US
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CLTC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // expander control link, asynchronous
  input wire loop_correction_enable,
  input wire trim_output_enable,
  input wire profile_select_bit0,
  input wire profile_select_bit1,
  input wire link_established,
  // adc result of this channel's own monitor input, same clock
  input wire [11:0] voltage_monitor_input,
  input wire voltage_monitor_valid,
  // trim output buffer
  output reg [7:0] trim_dac_code,
  output reg [1:0] trim_offset_sel,
  output reg trim_pad_oe
);

  // --------------------------------------------------------------------------
  // link input synchronisers
  // --------------------------------------------------------------------------
  reg [`CLTC_SYNC_W-1:0] sync1_ff;
  reg [`CLTC_SYNC_W-1:0] sync2_ff;
  reg [1:0] prof_prev_ff;
  wire cle_s;
  wire oe_s;
  wire [1:0] prof_s;
  wire link_s;

  // only sync2 is read by logic
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_ff <= {`CLTC_SYNC_W{1'b0}};
      sync2_ff <= {`CLTC_SYNC_W{1'b0}};
    end
    else
    begin
      sync1_ff <= {link_established, profile_select_bit1, profile_select_bit0,
                   trim_output_enable, loop_correction_enable};
      sync2_ff <= sync1_ff;
    end
  end

  assign cle_s = sync2_ff[0];
  assign oe_s = sync2_ff[1];
  assign prof_s = sync2_ff[3:2];
  assign link_s = sync2_ff[4];

  // --------------------------------------------------------------------------
  // configuration memory
  // --------------------------------------------------------------------------
  reg manual_ff;
  reg polarity_ff;
  reg [1:0] rate_ff;
  reg [7:0] prof_dac0_ff;
  reg [7:0] prof_dac1_ff;
  reg [7:0] prof_dac2_ff;
  reg [11:0] prof_sp0_ff;
  reg [11:0] prof_sp1_ff;
  reg [11:0] prof_sp2_ff;
  reg [11:0] setpoint_ff;
  reg [7:0] dac_ff;
  reg [1:0] cmp_ff;

  // apb access phase strobe; pready is already high in the first cycle of the access phase
  wire acc_done;
  wire wr_en;
  assign acc_done = psel & penable & pready;
  assign wr_en = acc_done & pwrite & ~pslverr;

  // software writes; offset select is rewritable at run time
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      manual_ff <= `CLTC_RST_MANUAL;
      polarity_ff <= `CLTC_RST_POLARITY;
      rate_ff <= `CLTC_RST_RATE;
      trim_offset_sel <= `CLTC_RST_OFFSET;
      prof_dac0_ff <= `CLTC_RST_PROF0_DAC;
      prof_dac1_ff <= `CLTC_RST_PROF1_DAC;
      prof_dac2_ff <= `CLTC_RST_PROF2_DAC;
      prof_sp0_ff <= `CLTC_RST_PROF0_SP;
      prof_sp1_ff <= `CLTC_RST_PROF1_SP;
      prof_sp2_ff <= `CLTC_RST_PROF2_SP;
    end
    else if (wr_en)
    begin
      case (paddr)
        `CLTC_OFS_CONFIG:
        begin
          manual_ff <= pwdata[`CLTC_CFG_MANUAL];
          polarity_ff <= pwdata[`CLTC_CFG_POLARITY];
          rate_ff <= pwdata[`CLTC_CFG_RATE_HI:`CLTC_CFG_RATE_LO];
          trim_offset_sel <= pwdata[`CLTC_CFG_OFFSET_HI:`CLTC_CFG_OFFSET_LO];
        end
        `CLTC_OFS_PROFILE_DAC:
        begin
          prof_dac0_ff <= pwdata[7:0];
          prof_dac1_ff <= pwdata[15:8];
          prof_dac2_ff <= pwdata[23:16];
        end
        `CLTC_OFS_PROFILE_SP01:
        begin
          prof_sp0_ff <= pwdata[11:0];
          prof_sp1_ff <= pwdata[27:16];
        end
        `CLTC_OFS_PROFILE_SP2: prof_sp2_ff <= pwdata[11:0];
        default: manual_ff <= manual_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // apb read and answer
  // --------------------------------------------------------------------------
  reg [31:0] nxt_prdata;
  reg nxt_err;

  // decode in the setup cycle so prdata is a flop by the access phase
  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    case (paddr)
      `CLTC_OFS_CONFIG:
      begin
        nxt_prdata[`CLTC_CFG_MANUAL] = manual_ff;
        nxt_prdata[`CLTC_CFG_POLARITY] = polarity_ff;
        nxt_prdata[`CLTC_CFG_RATE_HI:`CLTC_CFG_RATE_LO] = rate_ff;
        nxt_prdata[`CLTC_CFG_OFFSET_HI:`CLTC_CFG_OFFSET_LO] = trim_offset_sel;
      end
      `CLTC_OFS_PROFILE_DAC:
        nxt_prdata[23:0] = {prof_dac2_ff, prof_dac1_ff, prof_dac0_ff};
      `CLTC_OFS_PROFILE_SP01:
      begin
        nxt_prdata[11:0] = prof_sp0_ff;
        nxt_prdata[27:16] = prof_sp1_ff;
      end
      `CLTC_OFS_PROFILE_SP2:
        nxt_prdata[11:0] = prof_sp2_ff;
      `CLTC_OFS_STATUS:
      begin
        nxt_prdata[`CLTC_ST_DAC_HI:`CLTC_ST_DAC_LO] = dac_ff;
        nxt_prdata[`CLTC_ST_SP_HI:`CLTC_ST_SP_LO] = setpoint_ff;
        nxt_prdata[`CLTC_ST_OE] = trim_pad_oe;
        nxt_prdata[`CLTC_ST_LOOP] = cle_s & ~manual_ff;
        nxt_prdata[`CLTC_ST_CMP_HI:`CLTC_ST_CMP_LO] = cmp_ff;
      end
      default:
        nxt_err = 1'b1;
    endcase
    // status is read only, a write there is refused too
    if (pwrite && paddr == `CLTC_OFS_STATUS)
      nxt_err = 1'b1;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr <= nxt_err;
      pready <= 1'b1;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // shared correction interval timer
  // --------------------------------------------------------------------------
  reg [`CLTC_TMR_W-1:0] tmr_ff;
  reg [`CLTC_TMR_W-1:0] interval_cyc;
  wire tick;

  always @*
  begin
    case (rate_ff)
      2'h0: interval_cyc = INTERVAL0_CYC;
      2'h1: interval_cyc = INTERVAL1_CYC;
      2'h2: interval_cyc = INTERVAL2_CYC;
      default: interval_cyc = INTERVAL3_CYC;
    endcase
  end

  assign tick = (tmr_ff >= interval_cyc - {{(`CLTC_TMR_W-1){1'b0}}, 1'b1});

  // free running so all channels would see one common cadence
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tmr_ff <= {`CLTC_TMR_W{1'b0}};
    else if (tick)
      tmr_ff <= {`CLTC_TMR_W{1'b0}};
    else
      tmr_ff <= tmr_ff + {{(`CLTC_TMR_W-1){1'b0}}, 1'b1};
  end

  // --------------------------------------------------------------------------
  // profile selection
  // --------------------------------------------------------------------------
  wire [7:0] sel_dac;
  wire [11:0] sel_sp;
  wire prof_chg;

  // code 3 has no profile of its own and falls back to profile 2
  assign sel_dac = (prof_s == 2'h0) ? prof_dac0_ff :
                   (prof_s == 2'h1) ? prof_dac1_ff : prof_dac2_ff;
  assign sel_sp = (prof_s == 2'h0) ? prof_sp0_ff :
                  (prof_s == 2'h1) ? prof_sp1_ff : prof_sp2_ff;

  assign prof_chg = (prof_s != prof_prev_ff);

  // --------------------------------------------------------------------------
  // closed loop correction
  // --------------------------------------------------------------------------
  reg armed_ff;
  reg [1:0] nxt_cmp;
  wire loop_on;
  wire do_step;
  wire step_up;

  assign loop_on = cle_s & ~manual_ff;
  // the sample is this channel's own monitor only
  assign do_step = loop_on & armed_ff & voltage_monitor_valid;

  // three-state comparison of setpoint against sample
  always @*
  begin
    if (setpoint_ff > voltage_monitor_input)
      nxt_cmp = `CLTC_CMP_UP;
    else if (setpoint_ff < voltage_monitor_input)
      nxt_cmp = `CLTC_CMP_DN;
    else
      nxt_cmp = `CLTC_CMP_EQ;
  end

  assign step_up = (nxt_cmp == `CLTC_CMP_UP) ^ polarity_ff;

  // a tick arms one correction; it waits for the next fresh sample
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      armed_ff <= 1'b0;
    else if (!loop_on)
      armed_ff <= 1'b0;
    else if (tick)
      armed_ff <= 1'b1;
    else if (do_step)
      armed_ff <= 1'b0;
  end

  // setpoint register, dac register and comparison result
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prof_prev_ff <= 2'h0;
      setpoint_ff <= `CLTC_RST_PROF0_SP;
      dac_ff <= `CLTC_RST_MANUAL ? `CLTC_RST_PROF0_DAC : `CLTC_DAC_ZERO;
      cmp_ff <= `CLTC_CMP_EQ;
    end
    else
    begin
      prof_prev_ff <= prof_s;
      if (prof_chg)
        setpoint_ff <= sel_sp;
      if (manual_ff && prof_chg)
        dac_ff <= sel_dac;
      else if (do_step && nxt_cmp != `CLTC_CMP_EQ)
      begin
        if (step_up && dac_ff != `CLTC_DAC_MAX)
          dac_ff <= dac_ff + 8'h01;
        else if (!step_up && dac_ff != `CLTC_DAC_MIN)
          dac_ff <= dac_ff - 8'h01;
      end
      // otherwise held, also while correction is off
      if (do_step)
        cmp_ff <= nxt_cmp;
    end
  end

  // --------------------------------------------------------------------------
  // trim output buffer
  // --------------------------------------------------------------------------
  // enable waits for the link so the pad stays passive until then
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trim_pad_oe <= 1'b0;
      trim_dac_code <= `CLTC_DAC_ZERO;
    end
    else
    begin
      trim_pad_oe <= oe_s & link_s;
      trim_dac_code <= dac_ff;
    end
  end

endmodule // cltc_trim_cell

`default_nettype wire

// ---- verilog/cltc_consts.vh ----
`ifndef CLTC_CONSTS_VH
`define CLTC_CONSTS_VH

// ----------------------------------------------------------------------------
// clock and correction intervals
// ----------------------------------------------------------------------------
// sized at the timer width; the cycle products are formed in 22 bits and the largest, 2760000, fits
`define CLTC_CYC_PER_US 22'h64 // 100 MHz clock
`define CLTC_INTERVAL0_US 22'h35C // 860 us
`define CLTC_INTERVAL1_US 22'h6B8 // 1720 us
`define CLTC_INTERVAL2_US 22'h35E8 // 13800 us
`define CLTC_INTERVAL3_US 22'h6BD0 // 27600 us
`define CLTC_TMR_W 22

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CLTC_ADDR_W 12
`define CLTC_OFS_CONFIG 12'h000
`define CLTC_OFS_PROFILE_DAC 12'h004
`define CLTC_OFS_PROFILE_SP01 12'h008
`define CLTC_OFS_PROFILE_SP2 12'h00C
`define CLTC_OFS_STATUS 12'h010

// ----------------------------------------------------------------------------
// config register fields
// ----------------------------------------------------------------------------
`define CLTC_CFG_MANUAL 0
`define CLTC_CFG_POLARITY 1
`define CLTC_CFG_RATE_LO 2
`define CLTC_CFG_RATE_HI 3
`define CLTC_CFG_OFFSET_LO 4
`define CLTC_CFG_OFFSET_HI 5

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define CLTC_ST_DAC_LO 0
`define CLTC_ST_DAC_HI 7
`define CLTC_ST_SP_LO 8
`define CLTC_ST_SP_HI 19
`define CLTC_ST_OE 20
`define CLTC_ST_LOOP 21
`define CLTC_ST_CMP_LO 22
`define CLTC_ST_CMP_HI 23

// ----------------------------------------------------------------------------
// reset values of configuration memory
// ----------------------------------------------------------------------------
`define CLTC_RST_MANUAL 1'h0
`define CLTC_RST_POLARITY 1'h0
`define CLTC_RST_RATE 2'h0
`define CLTC_RST_OFFSET 2'h0
`define CLTC_RST_PROF0_DAC 8'h80
`define CLTC_RST_PROF1_DAC 8'h80
`define CLTC_RST_PROF2_DAC 8'h80
`define CLTC_RST_PROF0_SP 12'h800
`define CLTC_RST_PROF1_SP 12'h800
`define CLTC_RST_PROF2_SP 12'h800

// ----------------------------------------------------------------------------
// codes
// ----------------------------------------------------------------------------
`define CLTC_DAC_ZERO 8'h80
`define CLTC_DAC_MIN 8'h00
`define CLTC_DAC_MAX 8'hFF
`define CLTC_CMP_EQ 2'h0
`define CLTC_CMP_UP 2'h1
`define CLTC_CMP_DN 2'h3
`define CLTC_SYNC_W 5

`endif

// ---- dv/cltc_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// converter rail and adc seen from the trim cell
// ----------------------------------------------------------------------------
module cltc_adc_model #(
  parameter int PERIOD = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // level that the monitored rail settles at
  input wire logic [11:0] level,
  // conversion results
  output logic [11:0] voltage_monitor_input,
  output logic voltage_monitor_valid
);
  logic [3:0] cnt_ff;
  // one result every PERIOD cycles; between results the data carries the
  // inverse, so a stale value can never pass for a fresh one
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff <= 4'h0;
      voltage_monitor_valid <= 1'b0;
      voltage_monitor_input <= 12'h000;
    end
    else
    begin
      cnt_ff <= (cnt_ff == 4'(PERIOD - 1)) ? 4'h0 : cnt_ff + 4'h1;
      voltage_monitor_valid <= (cnt_ff == 4'h0);
      voltage_monitor_input <= (cnt_ff == 4'h0) ? level : ~level;
    end
  end
endmodule // cltc_adc_model
`default_nettype wire

// ---- dv/cltc_trim_cell_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// port checks of the trim cell
// ----------------------------------------------------------------------------
module cltc_trim_cell_assertions (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // control link and adc
  input wire loop_correction_enable,
  input wire trim_output_enable,
  input wire profile_select_bit0,
  input wire profile_select_bit1,
  input wire link_established,
  input wire voltage_monitor_valid,
  // trim output
  input wire [7:0] trim_dac_code,
  input wire [1:0] trim_offset_sel,
  input wire trim_pad_oe
);
  logic [3:0] quiet_ff;
  logic [3:0] off_ff;
  logic [1:0] ofs_ff;
  wire cfg_wr = psel & penable & pready & pwrite & (paddr == 12'h000);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles since a profile change and with the loop held off; profile jumps
  // are legal, so step checks wait until the selection has settled
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      quiet_ff <= 4'h0;
      off_ff <= 4'h0;
      ofs_ff <= 2'h0;
    end
    else
    begin
      if ($changed({profile_select_bit1, profile_select_bit0}))
        quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hF)
        quiet_ff <= quiet_ff + 4'h1;
      if (loop_correction_enable)
        off_ff <= 4'h0;
      else if (off_ff != 4'hF)
        off_ff <= off_ff + 4'h1;
      if (cfg_wr)
        ofs_ff <= pwdata[5:4];
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_step; $changed(trim_dac_code) && quiet_ff >= 4'h8; endsequence
  property p_pready_next; s_setup |=> pready; endproperty
  property p_pready_pulse; pready |=> !pready; endproperty
  property p_reset_state; $rose(rst_b) |-> !trim_pad_oe && trim_dac_code == 8'h80; endproperty
  property p_oe_cause; trim_pad_oe |-> $past(trim_output_enable, 3); endproperty
  property p_oe_link; trim_pad_oe |-> $past(link_established, 3); endproperty
  property p_one_step; s_step |-> (trim_dac_code - $past(trim_dac_code)) inside {8'h01, 8'hFF};
  endproperty
  property p_no_wrap;
    s_step |-> !(trim_dac_code == 8'h00 && $past(trim_dac_code) == 8'hFF) &&
               !(trim_dac_code == 8'hFF && $past(trim_dac_code) == 8'h00);
  endproperty
  property p_fresh_sample; s_step |-> $past(voltage_monitor_valid, 2); endproperty
  property p_hold_off; off_ff >= 4'h6 && quiet_ff >= 4'h8 |-> $stable(trim_dac_code); endproperty
  property p_offset; cfg_wr |-> ##[1:3] trim_offset_sel == ofs_ff; endproperty
  a_pready_next: assert property (p_pready_next) else $error("no ready after setup");
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
  a_oe_cause: assert property (p_oe_cause) else $error("pad driven while disabled");
  a_oe_link: assert property (p_oe_link) else $error("pad driven before link up");
  a_one_step: assert property (p_one_step) else $error("dac moved more than one");
  a_no_wrap: assert property (p_no_wrap) else $error("dac code wrapped");
  a_fresh_sample: assert property (p_fresh_sample) else $error("step without sample");
  a_hold_off: assert property (p_hold_off) else $error("dac moved with loop off");
  a_offset: assert property (p_offset) else $error("offset select not updated");
endmodule // cltc_trim_cell_assertions
bind cltc_trim_cell cltc_trim_cell_assertions u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .loop_correction_enable(loop_correction_enable), .trim_output_enable(trim_output_enable),
  .profile_select_bit0(profile_select_bit0), .profile_select_bit1(profile_select_bit1),
  .link_established(link_established), .voltage_monitor_valid(voltage_monitor_valid),
  .trim_dac_code(trim_dac_code), .trim_offset_sel(trim_offset_sel), .trim_pad_oe(trim_pad_oe));
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, trim_pad_oe;
  logic loop_correction_enable = 1'b0, trim_output_enable = 1'b0, link_established = 1'b0;
  logic profile_select_bit0 = 1'b0, profile_select_bit1 = 1'b0;
  logic [11:0] level = 12'h000;
  logic [11:0] voltage_monitor_input;
  logic voltage_monitor_valid;
  logic [7:0] trim_dac_code, d;
  logic [1:0] trim_offset_sel;
  int n_mismatch = 0, checks = 0, n;
  localparam int IV [4] = '{20, 30, 40, 50};
  // short intervals keep the run brief
  always #5 clk = ~clk;
  cltc_trim_cell #(.INTERVAL0_CYC(22'h14), .INTERVAL1_CYC(22'h1E), .INTERVAL2_CYC(22'h28),
    .INTERVAL3_CYC(22'h32)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_correction_enable(loop_correction_enable),
    .trim_output_enable(trim_output_enable), .profile_select_bit0(profile_select_bit0),
    .profile_select_bit1(profile_select_bit1), .link_established(link_established),
    .voltage_monitor_input(voltage_monitor_input), .voltage_monitor_valid(voltage_monitor_valid),
    .trim_dac_code(trim_dac_code), .trim_offset_sel(trim_offset_sel), .trim_pad_oe(trim_pad_oe));
  cltc_adc_model #(.PERIOD(2)) u_adc (.clk(clk), .rst_b(rst_b), .level(level),
    .voltage_monitor_input(voltage_monitor_input), .voltage_monitor_valid(voltage_monitor_valid));
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the extra leading edge keeps psel from toggling twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: only the watchdog may end a wait for ready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles until the dac code moves, bounded
  task automatic step(output int cyc);
    logic [7:0] d0;
    d0 = trim_dac_code;
    cyc = 0;
    while (trim_dac_code === d0 && cyc < 400)
    begin
      @(posedge clk);
      cyc++;
    end
  endtask
  task automatic stop_test;
    $display("counts: %0d mismatches in %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    chk(trim_dac_code, 8'h80);
    chk(trim_pad_oe, 1'b0);
    chk(trim_offset_sel, 2'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[19:8], 12'h800);
    chk(rd[21], 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h00808080);
    apb(1'b0, 12'h014, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(err, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_oe;
    trim_output_enable <= 1'b1;
    repeat (8) @(posedge clk);
    chk(trim_pad_oe, 1'b0);
    link_established <= 1'b1;
    repeat (8) @(posedge clk);
    chk(trim_pad_oe, 1'b1);
    trim_output_enable <= 1'b0;
    repeat (8) @(posedge clk);
    chk(trim_pad_oe, 1'b0);
    $display("output enable test done");
  endtask
  // profile and output first, loop enable last
  task automatic t_loop;
    apb(1'b1, 12'h008, 32'h03000200);
    profile_select_bit0 <= 1'b1;
    trim_output_enable <= 1'b1;
    level <= 12'h100;
    repeat (8) @(posedge clk);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[19:8], 12'h300);
    loop_correction_enable <= 1'b1;
    d = trim_dac_code;
    step(n);
    chk(trim_dac_code, d + 8'h01);
    level <= 12'h300;
    repeat (60) @(posedge clk);
    d = trim_dac_code;
    repeat (60) @(posedge clk);
    chk(trim_dac_code, d);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[23:22], 2'h0);
    apb(1'b1, 12'h000, 32'h2);
    level <= 12'h100;
    d = trim_dac_code;
    step(n);
    chk(trim_dac_code, d - 8'h01);
    loop_correction_enable <= 1'b0;
    repeat (8) @(posedge clk);
    d = trim_dac_code;
    repeat (100) @(posedge clk);
    chk(trim_dac_code, d);
    $display("loop test done");
  endtask
  task automatic t_rate;
    level <= 12'h000;
    loop_correction_enable <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, 12'h000, r << 2);
      step(n);
      step(n);
      step(n);
      chk(n, IV[r]);
    end
    $display("rate test done");
  endtask
  task automatic t_sat;
    apb(1'b1, 12'h000, 32'h0);
    repeat (4000) @(posedge clk);
    chk(trim_dac_code, 8'hFF);
    // rail above the setpoint gives the -1 result, so polarity 0 walks down
    level <= 12'hFFF;
    repeat (5600) @(posedge clk);
    chk(trim_dac_code, 8'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd[23:22], 2'h3);
    $display("saturation test done");
  endtask
  task automatic t_manual;
    apb(1'b1, 12'h004, 32'h003CA55A);
    apb(1'b1, 12'h000, 32'h31);
    profile_select_bit0 <= 1'b0;
    profile_select_bit1 <= 1'b1;
    repeat (8) @(posedge clk);
    chk(trim_dac_code, 8'h3C);
    chk(trim_offset_sel, 2'h3);
    profile_select_bit1 <= 1'b0;
    repeat (100) @(posedge clk);
    chk(trim_dac_code, 8'h5A);
    $display("manual test done");
  endtask
  // --------------------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_oe;
    t_loop;
    t_rate;
    t_sat;
    t_manual;
    stop_test;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
